// *** verilog/qsig_cfg.svh ***
// address maps, field positions and fixed values of the serial glue
`ifndef QSIG_CFG_SVH
`define QSIG_CFG_SVH
`define QSIG_WIN_BITS     3
`define QSIG_STAT_UNUSED  4'hF
`define QSIG_NUM_CHAN     4
`define QSIG_NUM_LEVELS   10
`define QSIG_MAP0 {10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8, 10'h220}
`define QSIG_MAP1 {10'h3E8, 10'h2E8, 10'h3A8, 10'h2A8, 10'h220}
`define QSIG_MAP2 {10'h380, 10'h388, 10'h288, 10'h230, 10'h224}
`define QSIG_MAP3 {10'h240, 10'h248, 10'h260, 10'h268, 10'h224}
`define QSIG_MAP4 {10'h100, 10'h108, 10'h110, 10'h118, 10'h240}
`define QSIG_MAP5 {10'h120, 10'h128, 10'h130, 10'h138, 10'h244}
`define QSIG_MAP6 {10'h140, 10'h148, 10'h150, 10'h158, 10'h248}
`define QSIG_MAP7 {10'h160, 10'h168, 10'h170, 10'h178, 10'h24C}
`define QSIG_LVL2   4'h0
`define QSIG_LVL3   4'h1
`define QSIG_LVL4   4'h2
`define QSIG_LVL5   4'h3
`define QSIG_LVL6   4'h4
`define QSIG_LVL7   4'h5
`define QSIG_LVL10  4'h6
`define QSIG_LVL11  4'h7
`define QSIG_LVL12  4'h8
`define QSIG_LVL15  4'h9
`endif

// *** verilog/qsig_pkg.sv ***
// types shared by the serial glue
package qsig_pkg;
    typedef enum logic [1:0] {
        QSIG_RS232,
        QSIG_RS422_P2P,
        QSIG_RS422_MD,
        QSIG_RS485_MD
    } qsig_proto_type;
    // per-channel modem inputs, active low as on the wire
    typedef struct packed {
        logic cts_n;
        logic dcd_n;
        logic dsr_n;
        logic ri_n;
    } qsig_modem_type;
    // host request-line outputs, one per level in order 2,3,4,5,6,7,10,11,12,15
    typedef struct packed {
        logic [9:0] out;
        logic [9:0] oe;
    } qsig_irq_type;
    typedef enum logic [1:0] {
        QSIG_IDLE,
        QSIG_READ
    } qsig_bus_state_type;
endpackage

// *** verilog/qsig_decode.sv ***
// address window decoder for four channels and the status byte
`include "qsig_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module qsig_decode (
    input  wire logic [2:0] map_sel,
    input  wire logic [9:0] addr,
    output logic      [3:0] chan_hit,
    output logic            stat_hit
);
    logic [49:0] map_w;
    always_comb begin
        case (map_sel)
            3'h0:    map_w = `QSIG_MAP0;
            3'h1:    map_w = `QSIG_MAP1;
            3'h2:    map_w = `QSIG_MAP2;
            3'h3:    map_w = `QSIG_MAP3;
            3'h4:    map_w = `QSIG_MAP4;
            3'h5:    map_w = `QSIG_MAP5;
            3'h6:    map_w = `QSIG_MAP6;
            default: map_w = `QSIG_MAP7;
        endcase
    end
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_win
            // base is the window's lowest address
            assign chan_hit[i] = (addr[9:`QSIG_WIN_BITS] ==
                                  map_w[49-10*i -: 7]);
        end
    endgenerate
    assign stat_hit = (addr == map_w[9:0]);
endmodule // qsig_decode
`default_nettype wire

// *** verilog/qsig_route.sv ***
// routes one channel request onto its chosen shared level
`include "qsig_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module qsig_route (
    input  wire logic       req,
    input  wire logic [3:0] level_sel,
    input  wire logic       bus16,
    output logic      [9:0] drive
);
    always_comb begin
        drive = 10'h000;
        // wide-bus levels unusable on a narrow host
        if (level_sel < 4'(`QSIG_NUM_LEVELS) &&
            (bus16 || level_sel <= `QSIG_LVL7)) begin
            drive[level_sel] = req;
        end
    end
endmodule // qsig_route
`default_nettype wire

// *** verilog/qsig_glue.sv ***
// top of the four-port serial board glue: decode, request routing, status, line control
//
// Contract
// - five regions are claimed: four eight-address channel windows and one status address.
// - three select inputs choose one of eight address maps of bases and status address.
// - a channel base is its window's lowest address and base plus zero to seven decodes to it.
// - each channel request is routed by its own selection to one of ten request levels.
// - levels 10, 11, 12 and 15 exist only with the wide bus; a narrow host has only 2 to 7.
// - with the wide bus present, level 2 appears to the host as level 9.
// - a pending request drives its line high and is otherwise released, never driven low.
// - the status byte returns live requests, channel 1 at bit 0 up to channel 4 at bit 3.
// - status bits show each channel's own request whatever the level sharing.
// - a status bit reads 1 while the request is active and 0 otherwise.
// - status bits 7 to 4 are unused and read as 1.
// - in multi-drop modes the line transmitter follows request-to-send, no auto switching.
// - in differential modes modem inputs may be forced true (0) per signal, never in RS-232.
// - RS-422 runs full duplex on two pairs, RS-485 half duplex on one pair.
`include "qsig_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module qsig_glue (
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic [2:0]            map_sel,
    input  wire logic                  bus16,
    input  wire logic [9:0]            addr,
    input  wire logic                  aen,
    input  wire logic                  ior_n,
    input  wire logic                  iow_n,
    output logic      [7:0]            data_out,
    output logic                       data_oe,
    output logic      [3:0]            uart_cs,
    output logic      [2:0]            uart_addr,
    input  wire logic [3:0]            uart_req,
    input  wire logic [3:0]            uart_rts_n,
    input  wire logic [15:0]           level_sel,
    input  wire qsig_pkg::qsig_proto_type [3:0] proto,
    input  wire logic [15:0]           force_true,
    input  wire qsig_pkg::qsig_modem_type [3:0] line_modem,
    output qsig_pkg::qsig_modem_type [3:0]     uart_modem,
    output logic      [3:0]            tx_en,
    output logic      [3:0]            rx_en,
    output qsig_pkg::qsig_irq_type     irq,
    output logic                       irq9_out,
    output logic                       irq9_oe
);
    ////////////////////////////////////////////////////////////////////////
    // address decode
    logic [3:0] chan_hit;
    logic       stat_hit;
    logic       stat_rd;
    qsig_decode u_decode (
        .map_sel  (map_sel),
        .addr     (addr),
        .chan_hit (chan_hit),
        .stat_hit (stat_hit)
    );
    // dma cycles hold aen high and must not select anything
    assign uart_cs   = aen ? 4'h0 : chan_hit;
    assign uart_addr = addr[2:0];
    assign stat_rd   = !aen && stat_hit && !ior_n;

    ////////////////////////////////////////////////////////////////////////
    // request routing
    logic [9:0] drive_ch [4];
    logic [9:0] drive_all;
    logic [3:0] req_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            req_reg <= 4'h0;
        end else if (clk_en) begin
            req_reg <= uart_req;
        end
    end
    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_route
            qsig_route u_route (
                .req       (req_reg[i]),
                .level_sel (level_sel[4*i +: 4]),
                .bus16     (bus16),
                .drive     (drive_ch[i])
            );
        end
    endgenerate
    assign drive_all = drive_ch[0] | drive_ch[1] | drive_ch[2] | drive_ch[3];
    // high while pending, float otherwise; lets sources share one line
    always_comb begin
        irq.out  = drive_all;
        irq.oe   = drive_all;
        irq9_out = 1'b0;
        irq9_oe  = 1'b0;
        if (bus16) begin
            irq.out[`QSIG_LVL2] = 1'b0;
            irq.oe[`QSIG_LVL2]  = 1'b0;
            irq9_out = drive_all[`QSIG_LVL2];
            irq9_oe  = drive_all[`QSIG_LVL2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status byte read path
    logic [7:0] data_reg;
    logic       oe_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            data_reg <= 8'h00;
            oe_reg   <= 1'b0;
        end else if (clk_en) begin
            // per-channel request, not the shared line, so sharing cannot mask it
            data_reg <= {`QSIG_STAT_UNUSED, req_reg};
            oe_reg   <= stat_rd;
        end
    end
    assign data_out = data_reg;
    assign data_oe  = oe_reg && stat_rd;

    ////////////////////////////////////////////////////////////////////////
    // line transceiver control and modem input forcing
    generate
        for (i = 0; i < 4; i++) begin : g_line
            logic diff;
            logic multi;
            assign diff  = proto[i] != qsig_pkg::QSIG_RS232;
            assign multi = proto[i] == qsig_pkg::QSIG_RS422_MD ||
                           proto[i] == qsig_pkg::QSIG_RS485_MD;
            // software drives rts; no automatic turnaround
            assign tx_en[i] = multi ? !uart_rts_n[i] : 1'b1;
            // single pair: listen only while not talking
            assign rx_en[i] = (proto[i] == qsig_pkg::QSIG_RS485_MD) ?
                              uart_rts_n[i] : 1'b1;
            assign uart_modem[i].cts_n = line_modem[i].cts_n &
                                         !(diff && force_true[4*i+3]);
            assign uart_modem[i].dcd_n = line_modem[i].dcd_n &
                                         !(diff && force_true[4*i+2]);
            assign uart_modem[i].dsr_n = line_modem[i].dsr_n &
                                         !(diff && force_true[4*i+1]);
            assign uart_modem[i].ri_n  = line_modem[i].ri_n &
                                         !(diff && force_true[4*i]);
        end
    endgenerate
endmodule // qsig_glue
`default_nettype wire

// *** tb/qsig_glue_sva.sv ***
// assertion checker of the serial glue top
`timescale 1ns/100ps
`default_nettype none
module qsig_glue_sva (
    input wire logic                   mclk,
    input wire logic                   rstn,
    input wire logic                   bus16,
    input wire logic                   aen,
    input wire logic                   ior_n,
    input wire logic [7:0]             data_out,
    input wire logic                   data_oe,
    input wire logic [3:0]             uart_cs,
    input wire logic [3:0]             uart_req,
    input wire logic [15:0]            level_sel,
    input wire qsig_pkg::qsig_irq_type irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_oe_on_read: assert property (data_oe |-> !ior_n && !aen)
        else $error("data driven outside read");
    a_upper_ones: assert property (data_oe |-> data_out[7:4] == 4'hF)
        else $error("unused bits not one");
    // request register then status register: two edges from pin to byte
    a_live_state: assert property (data_oe |-> data_out[3:0] == $past(uart_req, 2))
        else $error("status not live");
    a_never_low: assert property (irq.out == irq.oe)
        else $error("level driven low");
    a_narrow_bus: assert property (!bus16 |-> irq.oe[9:6] == 4'h0)
        else $error("wide level on narrow bus");
    a_lvl_nine: assert property (bus16 |-> !irq.oe[0])
        else $error("level 2 not moved");
    a_dma_block: assert property (aen |-> uart_cs == 4'h0 && !data_oe)
        else $error("decode during dma");
    a_route_one: assert property ($past(rstn) && $past(uart_req[0]) && level_sel[3:0] == 4'h1
        |-> irq.oe[1])
        else $error("request not routed");
    c_read: cover property (data_oe);
    c_wide: cover property (irq.oe[9]);
    c_route: cover property (irq.oe[1]);
endmodule // qsig_glue_sva
bind qsig_glue qsig_glue_sva u_sva (.*);
`default_nettype wire

// *** tb/qsig_host.sv ***
// host bus master model for status and window cycles
`timescale 1ns/100ps
`default_nettype none
module qsig_host (
    input  wire logic       mclk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic      [9:0] addr  = 10'h000,
    output logic            aen   = 1'b0,
    output logic            ior_n = 1'b1,
    output logic            iow_n = 1'b1
);
    // one strobe cycle; answer taken before the strobe is released
    task automatic cyc(input logic w, input logic [9:0] a, output logic [8:0] r);
        @(negedge mclk);
        addr  = a;
        ior_n = w;
        iow_n = !w;
        @(negedge mclk);
        r     = {data_oe, data_out};
        ior_n = 1'b1;
        iow_n = 1'b1;
        addr  = ~a; // released bus must not keep the last address
    endtask
endmodule // qsig_host
`default_nettype wire

// *** tb/quad_serial_addr_irq_glue_tb.sv ***
// bench of the serial glue: decode, status, routing, line control
`include "qsig_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module quad_serial_addr_irq_glue_tb;
    logic                           mclk = 1'b0;
    logic                           rstn = 1'b0;
    logic                           clk_en = 1'b1;
    logic [2:0]                     map_sel = 3'h0;
    logic                           bus16 = 1'b0;
    logic [3:0]                     uart_req = 4'h0;
    logic [3:0]                     uart_rts_n = 4'hF;
    logic [15:0]                    level_sel = 16'hFFFF;
    qsig_pkg::qsig_proto_type [3:0] proto = {4{qsig_pkg::QSIG_RS232}};
    logic [15:0]                    force_true = 16'h000F;
    logic [15:0]                    line_modem = 16'hFFFF;
    logic [9:0]                     addr;
    logic                           aen, ior_n, iow_n, data_oe, irq9_out, irq9_oe;
    logic [7:0]                     data_out;
    logic [3:0]                     uart_cs, tx_en, rx_en;
    logic [2:0]                     uart_addr;
    logic [15:0]                    uart_modem;
    qsig_pkg::qsig_irq_type         irq;
    logic [49:0]                    mp [8] = '{`QSIG_MAP0, `QSIG_MAP1, `QSIG_MAP2,
        `QSIG_MAP3, `QSIG_MAP4, `QSIG_MAP5, `QSIG_MAP6, `QSIG_MAP7};
    int                             n_mismatch = 0;
    int                             tests_run = 0;
    logic [8:0]                     r;
    ////////////////////////////////////////
    qsig_glue dut (.mclk, .rstn, .clk_en, .map_sel, .bus16, .addr, .aen, .ior_n,
        .iow_n, .data_out, .data_oe, .uart_cs, .uart_addr, .uart_req, .uart_rts_n,
        .level_sel, .proto, .force_true, .line_modem, .uart_modem, .tx_en, .rx_en, .irq,
        .irq9_out, .irq9_oe);
    qsig_host host (.mclk, .data_out, .data_oe, .addr, .aen, .ior_n, .iow_n);
    always #2 mclk = ~mclk;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (e !== g) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge mclk);
        n_mismatch++;
        stop_test();
    end
    ////////////////////////////////////////
    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        for (int m = 0; m < 8; m++) begin
            map_sel = 3'(m);
            uart_req = 4'(m);
            for (int c = 0; c < 4; c++) begin
                @(negedge mclk);
                host.addr = mp[m][49-10*c -: 10] + 10'h007;
                #1 chk("uart_cs", 16'(1 << c), 16'(uart_cs));
                chk("uart_addr", 16'h0007, 16'(uart_addr));
            end
            host.cyc(1'b0, mp[m][9:0], r);
            chk("status", 16'({1'b1, 4'hF, 4'(m)}), 16'(r));
        end
        host.aen = 1'b1;
        host.cyc(1'b0, 10'h24C, r);
        chk("dma_oe", 16'h0000, 16'(r[8]));
        host.aen = 1'b0;
        host.cyc(1'b1, 10'h24C, r);
        chk("write_oe", 16'h0000, 16'(r[8]));
        level_sel = 16'h1111;
        uart_req = 4'hB;
        host.cyc(1'b0, 10'h24C, r);
        chk("shared", 16'h01FB, 16'(r));
        chk("irq_shared", 16'h0002, 16'(irq.oe));
        clk_en = 1'b0;
        uart_req = 4'h0;
        @(negedge mclk);
        chk("irq_frozen", 16'h0002, 16'(irq.oe));
        clk_en = 1'b1;
        @(negedge mclk);
        chk("irq_thawed", 16'h0000, 16'(irq.oe));
        for (int l = 0; l < 10; l++) begin
            level_sel = ~(16'(4'(l) ^ 4'hF) << (4 * (l % 4)));
            uart_req = 4'(1 << (l % 4));
            bus16 = 1'b1;
            @(negedge mclk);
            chk("irq_wide", (l == 0) ? 16'h0 : 16'(1 << l), 16'(irq.oe));
            chk("irq9", (l == 0) ? 16'h3 : 16'h0, {14'h0, irq9_out, irq9_oe});
            #1 bus16 = 1'b0;
            #1 chk("irq_narrow", (l > 5) ? 16'h0 : 16'(1 << l), 16'(irq.out));
            uart_req = 4'h0;
            @(negedge mclk);
            chk("irq_off", 16'h0000, 16'(irq.oe));
        end
        for (int p = 0; p < 8; p++) begin
            proto[0] = qsig_pkg::qsig_proto_type'(p[1:0]);
            uart_rts_n[0] = p[2];
            @(negedge mclk);
            chk("modem", (p % 4 == 0) ? 16'hF : 16'h0, 16'(uart_modem[3:0]));
            chk("tx_en", (p % 4 > 1) ? 16'(!p[2]) : 16'h1, 16'(tx_en[0]));
            chk("rx_en", (p % 4 == 3) ? 16'(p[2]) : 16'h1, 16'(rx_en[0]));
        end
        stop_test();
    end
endmodule // quad_serial_addr_irq_glue_tb
`default_nettype wire
